// ==== ustore_seq.sv ====
// Microstore sequencing, break-in, restore and parity checks behind an AHB-Lite slave
////////////////////////////////////////////////////////////////////////////
// Functional notes
// RL1 - One microsecond store cycle split into four phases sequencing all actions.
// RL2 - Microaddress loads every latch at phase one; absent bit input clears latch.
// RL3 - After address settles, phase two drive pulse addresses the array.
// RL4 - Delayed drive pulse strobes sense latches at phase four; drive clears them.
// RL5 - Sense contents valid from phase four until part way through phase three.
// RL6 - Sense word reaches control latches at next phase one; stop holds both.
// RL7 - When control latch set and reset coincide, set wins.
// RL8 - Break-in requested in phase four saves microaddress into backup at phase four.
// RL9 - First interruption cycle suppresses control latch set: a dead cycle.
// RL10 - Dead cycle phase one forces alternate routine start address.
// RL11 - Dead cycle phase one saves resolved branch bits into backup branch latches.
// RL12 - Final alternate step phase one gates saved address back to microaddress.
// RL13 - Restore-buffer latch sets at phase two on a reload-from-backup order.
// RL14 - Restore latch sets from restore-buffer at phase four; gates backup branch bits.
// RL15 - First resumed cycle forms branch bits from backup latches at phase one.
// RL16 - Sense latches sampled at phase two; even parity sets check bit four.
// RL17 - Control latches checked at phase four; failure sets bit three, may block indicator.
// RL18 - Address parities plus third check bit must be odd, else bit five at phase two.
// RL19 - Bad sense parity blocks drive; check stop keeps failing word address.
// RL20 - Control field parity is checked on sense latch contents for those fields.
// RL21 - Microaddress has fifteen latches: thirteen address, two parity.
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
module ustore_seq
    import ustore_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [CW_W-1:0] cs_word,
    input wire uaddr_t next_addr,
    input wire uaddr_t alt_start_addr,
    input wire logic break_req,
    input wire logic return_req,
    input wire logic restore_order,
    input wire logic cond_bit_a,
    input wire logic cond_bit_b,
    input wire logic third_check_bit,
    output uaddr_t microaddress_reg,
    output logic array_drive,
    output logic [CW_W-1:0] control_word
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    timing_t tm;
    logic [1:0] control_q;
    logic run_req;
    logic stop_sel;
    logic halted;
    // RL21 fifteen latches
    uaddr_t ua_q;
    uaddr_t saved_microaddress;
    uaddr_t word_addr_q;
    uaddr_t indicate_q;
    logic [CW_W-1:0] sense_latches;
    logic sense_full_q;
    logic [CW_W-1:0] ctrl_q;
    logic ctrl_par_ok_q;
    logic drive_q;
    logic break_seen_q;
    logic dead_q;
    logic restore_buf_q;
    logic restore_q;
    logic branch_bit_a;
    logic branch_bit_b;
    logic addr_chk_q;
    logic ctrl_err;
    logic sense_bad;
    logic addr_bad;
    logic [MC_W-1:0] mc_q;
    logic [MC_W-1:0] mc_set;
    logic [MC_W-1:0] mc_clr;
    logic ap_valid;
    logic wr_q;
    logic [7:0] waddr_q;
    logic [31:0] rd_mux;

    assign run_req = control_q[CTL_RUN_BIT];
    assign stop_sel = control_q[CTL_STOP_BIT];
    // A check stop halts the cycle so the failing state can be inspected
    assign halted = stop_sel && (mc_q != MC_RESET);

    ////////////////////////////////////////////////////////////////////////
    // Phase timing
    // RL1 four phase cycle
    phase_gen u_phase (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run_req && !halted),
        .timing(tm)
    );

    ////////////////////////////////////////////////////////////////////////
    // Parity terms
    // RL16 sense odd parity
    assign sense_bad = sense_full_q && ~(^sense_latches);
    // RL18 three-bit odd parity
    assign addr_bad = ~(ua_q.par_w ^ ua_q.par_x ^ third_check_bit);
    // RL17 control latch check
    assign ctrl_err = !ctrl_par_ok_q;

    ////////////////////////////////////////////////////////////////////////
    // Microaddress register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ua_q <= UADDR_RESET;
        end else if (tm.drive_pulse && sense_bad && stop_sel) begin
            // RL19 keep failing address
            ua_q <= word_addr_q;
        end else if (tm.set_pulse) begin
            if (dead_q) begin
                // RL10 force alternate start
                ua_q <= alt_start_addr;
            end else if (return_req) begin
                // RL12 resume interrupted routine
                ua_q <= saved_microaddress;
            end else if (restore_q) begin
                // RL15 branch from backup
                ua_q <= {next_addr[UADDR_W-1:2], branch_bit_a, branch_bit_b};
            end else begin
                // RL2 full reload each cycle
                ua_q <= next_addr;
            end
        end
    end

    assign microaddress_reg = ua_q;

    // Address of the word now held in the sense latches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_addr_q <= UADDR_RESET;
        end else if (tm.strobe) begin
            word_addr_q <= ua_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Array drive and sense latches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_q <= 1'b0;
        end else if (tm.drive_pulse) begin
            // RL3 drive selected lines
            // RL19 bad sense blocks drive
            drive_q <= !sense_bad;
        end else if (tm.strobe) begin
            drive_q <= 1'b0;
        end
    end

    assign array_drive = drive_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sense_latches <= WORD_RESET;
            sense_full_q <= 1'b0;
        end else if (tm.strobe) begin
            // RL4 delayed strobe loads
            sense_latches <= cs_word;
            sense_full_q <= drive_q;
        end else if (tm.sense_clear) begin
            // RL5 valid into phase three
            // RL4 drive clears beforehand
            sense_latches <= WORD_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control latches
    // Set and reset share the phase one window; a plain clear in the dead cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= WORD_RESET;
            ctrl_par_ok_q <= 1'b1;
        end else if (tm.set_pulse && !dead_q) begin
            // RL6 transfer at phase one
            // RL7 set beats reset
            ctrl_q <= sense_latches;
            // RL20 check taken on sense
            ctrl_par_ok_q <= !sense_bad;
        end else if (tm.set_pulse) begin
            // RL9 dead cycle no set
            ctrl_q <= WORD_RESET;
            ctrl_par_ok_q <= 1'b1;
        end
    end

    assign control_word = ctrl_q;

    ////////////////////////////////////////////////////////////////////////
    // Break-in and dead cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            break_seen_q <= 1'b0;
        end else if (tm.four_end) begin
            break_seen_q <= 1'b0;
        end else if (break_req && (tm.phase == PH_FOUR)) begin
            break_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            saved_microaddress <= UADDR_RESET;
            dead_q <= 1'b0;
        end else if (tm.four_end && (break_seen_q || break_req)) begin
            // RL8 backup at phase four
            saved_microaddress <= ua_q;
            dead_q <= 1'b1;
        end else if (tm.set_pulse) begin
            dead_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            branch_bit_a <= 1'b0;
            branch_bit_b <= 1'b0;
        end else if (tm.set_pulse && dead_q) begin
            // RL11 save branch bits
            branch_bit_a <= cond_bit_a;
            branch_bit_b <= cond_bit_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Restore latches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restore_buf_q <= 1'b0;
        end else if (tm.drive_pulse && restore_order) begin
            // RL13 buffer set at phase two
            restore_buf_q <= 1'b1;
        end else if (tm.strobe) begin
            restore_buf_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restore_q <= 1'b0;
        end else if (tm.strobe) begin
            // RL14 restore set at phase four
            restore_q <= restore_buf_q;
        end else if (tm.set_pulse) begin
            restore_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicating address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            indicate_q <= UADDR_RESET;
        end else if (tm.four_end && !(ctrl_err && stop_sel)) begin
            // RL17 stop blocks indicator
            indicate_q <= ua_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Machine check register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_chk_q <= 1'b0;
        end else begin
            // RL18 address check latch
            addr_chk_q <= addr_bad;
        end
    end

    always_comb begin
        mc_set = MC_RESET;
        // RL16 even count sets four
        mc_set[MC_SENSE_POS] = tm.drive_pulse && sense_bad;
        // RL17 failure sets three
        mc_set[MC_CTRL_POS] = tm.strobe && ctrl_err;
        // RL18 latch at phase two
        mc_set[MC_ADDR_POS] = tm.drive_pulse && addr_chk_q;
    end

    assign mc_clr = (wr_q && (waddr_q == OFF_MCHECK)) ? hwdata[MC_W-1:0] : MC_RESET;

    // A check arriving with its clear is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_q <= MC_RESET;
        end else begin
            mc_q <= (mc_q & ~mc_clr) | mc_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY
    assign ap_valid = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            waddr_q <= 8'h00;
        end else begin
            wr_q <= ap_valid && hwrite;
            waddr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_q <= CONTROL_RESET;
        end else if (wr_q && (waddr_q == OFF_CONTROL)) begin
            control_q <= hwdata[1:0];
        end
    end

    // Read data is latched at the address phase so it stands as a flop
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            OFF_CONTROL: rd_mux[1:0] = control_q;
            OFF_STATUS: rd_mux[7:0] = {addr_chk_q, halted, restore_q, restore_buf_q, dead_q, drive_q, tm.phase};
            OFF_MCHECK: rd_mux[MC_W-1:0] = mc_q;
            OFF_UADDR: rd_mux[UADDR_W-1:0] = ua_q;
            OFF_SAVED: rd_mux[UADDR_W-1:0] = saved_microaddress;
            OFF_INDICATE: rd_mux[UADDR_W-1:0] = indicate_q;
            OFF_SENSE: rd_mux = sense_latches;
            OFF_CTRLWORD: rd_mux = ctrl_q;
            OFF_BRANCH: rd_mux[1:0] = {branch_bit_a, branch_bit_b};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_valid && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

endmodule : ustore_seq

// ==== ustore_pkg.sv ====
// Shared constants, types and register map of the microstore sequencer
package ustore_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int STORE_CYCLE_NS = 1000;
    localparam int PHASES_PER_CYCLE = 4;
    localparam int PHASE_CYCLES = STORE_CYCLE_NS / CLK_PERIOD_NS / PHASES_PER_CYCLE;
    localparam logic [5:0] PHASE_LAST = 6'(PHASE_CYCLES - 1);
    // Sense latches stay good part way into phase three
    localparam logic [5:0] SENSE_CLEAR_TICK = 6'(PHASE_CYCLES / 2);

    ////////////////////////////////////////////////////////////////////////
    // Widths and field positions
    localparam int UADDR_W = 15;
    localparam int CW_W = 32;
    localparam int MC_W = 8;
    localparam int MC_CTRL_POS = 3;
    localparam int MC_SENSE_POS = 4;
    localparam int MC_ADDR_POS = 5;
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_STOP_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MCHECK = 8'h08;
    localparam logic [7:0] OFF_UADDR = 8'h0C;
    localparam logic [7:0] OFF_SAVED = 8'h10;
    localparam logic [7:0] OFF_INDICATE = 8'h14;
    localparam logic [7:0] OFF_SENSE = 8'h18;
    localparam logic [7:0] OFF_CTRLWORD = 8'h1C;
    localparam logic [7:0] OFF_BRANCH = 8'h20;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [1:0] CONTROL_RESET = 2'h0;
    localparam logic [UADDR_W-1:0] UADDR_RESET = 15'h0000;
    localparam logic [CW_W-1:0] WORD_RESET = 32'h0000_0000;
    localparam logic [MC_W-1:0] MC_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        PH_ONE,
        PH_TWO,
        PH_THREE,
        PH_FOUR
    } phase_t;

    // Microaddress: two parity latches and thirteen address latches
    typedef struct packed {
        logic par_w;
        logic par_x;
        logic [4:0] w;
        logic [7:0] x;
    } uaddr_t;

    typedef struct packed {
        phase_t phase;
        logic set_pulse;
        logic drive_pulse;
        logic strobe;
        logic sense_clear;
        logic four_end;
    } timing_t;

endpackage : ustore_pkg

// ==== phase_gen.sv ====
// Four-phase store cycle generator with stop at the end of phase four
module phase_gen
    import ustore_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    output timing_t timing
);

    logic [5:0] tick_q;
    phase_t phase_q;
    logic advance;
    logic [3:0] enter_q;

    // A stopped clock always rests at the last tick of phase four
    assign advance = (tick_q == PHASE_LAST) && ((phase_q != PH_FOUR) || run);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= PHASE_LAST;
        end else if (advance) begin
            tick_q <= 6'h00;
        end else if (tick_q != PHASE_LAST) begin
            tick_q <= tick_q + 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= PH_FOUR;
            enter_q <= 4'h0;
        end else begin
            enter_q <= 4'h0;
            if (advance) begin
                case (phase_q)
                    PH_ONE: begin
                        phase_q <= PH_TWO;
                        enter_q <= 4'h2;
                    end
                    PH_TWO: begin
                        phase_q <= PH_THREE;
                        enter_q <= 4'h4;
                    end
                    PH_THREE: begin
                        phase_q <= PH_FOUR;
                        enter_q <= 4'h8;
                    end
                    default: begin
                        phase_q <= PH_ONE;
                        enter_q <= 4'h1;
                    end
                endcase
            end
        end
    end

    always_comb begin
        timing.phase = phase_q;
        timing.set_pulse = enter_q[0];
        timing.drive_pulse = enter_q[1];
        timing.strobe = enter_q[3];
        timing.sense_clear = (phase_q == PH_THREE) && (tick_q == SENSE_CLEAR_TICK);
        timing.four_end = advance && (phase_q == PH_FOUR);
    end

endmodule : phase_gen

// ==== ustore_seq_monitor.sv ====
// Port-level checks of the microstore sequencer
module ustore_seq_monitor
    import ustore_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [CW_W-1:0] cs_word,
    input wire logic break_req,
    input wire logic return_req,
    input wire uaddr_t microaddress_reg,
    input wire logic array_drive,
    input wire logic [CW_W-1:0] control_word
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [9:0] gap_q;
    logic [9:0] hi_q;
    logic par_q;
    ////////////////////////////////////////////////////////////////////////
    // Cycle spacing, drive length, sense parity near the strobe
    always_ff @(posedge hclk) begin
        if (!hresetn) begin
            gap_q <= 10'h3FF;
            hi_q <= 10'h000;
            par_q <= 1'b1;
        end else begin
            gap_q <= $rose(array_drive) ? 10'h000 : gap_q + {9'h000, gap_q != 10'h3FF};
            hi_q <= array_drive ? hi_q + 10'h001 : 10'h000;
            if ($fell(array_drive)) begin
                par_q <= ^cs_word;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // address settled under drive
    property p_addr_hold; array_drive |-> $stable(microaddress_reg); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved under drive");
    property p_addr_once; $changed(microaddress_reg) |=> $stable(microaddress_reg) [*8]; endproperty
    a_addr_once: assert property (p_addr_once) else $error("address reloaded too soon");
    property p_ctrl_addr; $changed(control_word) |-> gap_q >= 10'h095; endproperty
    a_ctrl_addr: assert property (p_ctrl_addr) else $error("control word loaded early");
    property p_ctrl_idle; $changed(control_word) |-> !array_drive && !$past(array_drive); endproperty
    a_ctrl_idle: assert property (p_ctrl_idle) else $error("control word loaded in drive");
    property p_ctrl_hold; $changed(control_word) |=> $stable(control_word) [*8]; endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control word unstable");
    property p_drive_gap; $rose(array_drive) |-> gap_q >= 10'd199; endproperty
    a_drive_gap: assert property (p_drive_gap) else $error("store cycle too short");
    // drive spans phases two and three
    property p_drive_len; $fell(array_drive) |-> hi_q >= 10'd98 && hi_q <= 10'd101; endproperty
    a_drive_len: assert property (p_drive_len) else $error("drive length wrong");
    property p_sense_par; $rose(array_drive) |-> par_q; endproperty
    a_sense_par: assert property (p_sense_par) else $error("drive after bad sense word");
    c_break: cover property (break_req && !array_drive);
    c_return: cover property ($rose(return_req));
    c_drive: cover property ($fell(array_drive) ##1 !array_drive [*8]);
endmodule : ustore_seq_monitor

// ==== ustore_model.sv ====
// Control store array model answering the array drive with stored words
module ustore_model
    import ustore_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire uaddr_t microaddress_reg,
    input wire logic array_drive,
    input wire logic corrupt,
    output logic [CW_W-1:0] cs_word
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] hold_q;
    logic [CW_W-1:0] pat_q;
    // Each bit beside its inverse gives fifteen ones, so odd parity
    function automatic logic [CW_W-1:0] word_of(input logic [UADDR_W-1:0] a);
        return {~a, 2'b00, a};
    endfunction : word_of
    always_ff @(posedge hclk) begin
        if (!hresetn || array_drive) begin
            hold_q <= hresetn ? 4'h0 : 4'hA;
        end else if (hold_q != 4'hA) begin
            hold_q <= hold_q + 4'h1;
        end
        pat_q <= hresetn ? ~pat_q : 32'h0000_0000;
    end
    // Sense amps keep the word only briefly after the drive drops
    assign cs_word = (array_drive || hold_q != 4'hA) ?
        word_of(microaddress_reg) ^ {16'h0000, corrupt, 15'h0000} : pat_q;
endmodule : ustore_model

// ==== ustore_seq_tb.sv ====
// Self-checking bench of the microstore sequencer
module ustore_seq_tb
    import ustore_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [14:0] A1 = 15'h0101;
    localparam logic [14:0] A2 = 15'h0202;
    localparam logic [14:0] ALT = 15'h0343;
    localparam logic [14:0] ALT2 = 15'h0344;
    localparam logic [14:0] NXT = 15'h0205;
    localparam logic [14:0] BAD = 15'h0411;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, array_drive, corrupt;
    logic break_req, return_req, restore_order, cond_bit_a, cond_bit_b, third_check_bit;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [CW_W-1:0] cs_word, control_word;
    uaddr_t next_addr, alt_start_addr, microaddress_reg;
    int err_count = 0;
    int comparisons = 0;
    ustore_seq ustore_seq_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cs_word, .next_addr, .alt_start_addr,
        .break_req, .return_req, .restore_order, .cond_bit_a, .cond_bit_b, .third_check_bit,
        .microaddress_reg, .array_drive, .control_word);
    ustore_model ustore_model_i (.hclk, .hresetn, .microaddress_reg, .array_drive, .corrupt, .cs_word);
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    // Address phase held until ready, then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string msg);
        bus(a, 1'b0, 32'h0000_0000);
        chk(rd & mask, exp, msg);
    endtask : rd_chk
    // Waits for n edges of the drive to the given level
    task automatic wait_drive(input int n, input logic lvl);
        int k;
        repeat (n) begin
            k = 0;
            while (array_drive === lvl && k < 400) begin @(negedge hclk); k++; end
            while (array_drive !== lvl && k < 400) begin @(negedge hclk); k++; end
            chk(32'(k < 400), 32'h1, "drive edge missing");
        end
        @(posedge hclk);
    endtask : wait_drive
    function automatic logic [31:0] word(input logic [14:0] a);
        return ustore_model_i.word_of(a);
    endfunction : word
    ////////////////////////////////////////////////////////////////////////
    task automatic test_regs;
        rd_chk(OFF_CONTROL, 32'hFFFF_FFFF, 32'h0000_0000, "control reset");
        chk(32'(hresp), 32'h0, "okay response");
        rd_chk(OFF_UADDR, 32'hFFFF_FFFF, 32'h0000_0000, "address reset");
        bus(OFF_STATUS, 1'b1, 32'hFFFF_FFFF);
        rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    endtask : test_regs
    // Stop in phase four leaves new word in sense latches only
    task automatic test_stop;
        bus(OFF_CONTROL, 1'b1, 32'h0000_0001);
        wait_drive(1, 1'b1);
        chk(microaddress_reg, A1, "address at phase one");
        next_addr <= A2;
        wait_drive(1, 1'b0);
        bus(OFF_CONTROL, 1'b1, 32'h0000_0000);
        repeat (60) @(posedge hclk);
        rd_chk(OFF_SENSE, 32'hFFFF_FFFF, word(A1), "sense after stop");
        chk(control_word, 32'h0000_0000, "control after stop");
    endtask : test_stop
    // Break-in, dead cycle, alternate routine and return
    task automatic test_break;
        bus(OFF_CONTROL, 1'b1, 32'h0000_0001);
        wait_drive(1, 1'b1);
        chk(control_word, word(A1), "control after resume");
        wait_drive(1, 1'b0);
        repeat (5) @(posedge hclk);
        break_req <= 1'b1;
        repeat (10) @(posedge hclk);
        break_req <= 1'b0;
        wait_drive(1, 1'b1);
        chk(microaddress_reg, ALT, "alternate start");
        chk(control_word, 32'h0000_0000, "dead cycle control");
        rd_chk(OFF_SAVED, 32'h0000_7FFF, A2, "saved address");
        rd_chk(OFF_BRANCH, 32'h0000_0003, 32'h0000_0002, "saved branch bits");
        cond_bit_a <= 1'b0;
        cond_bit_b <= 1'b1;
        next_addr <= ALT2;
        wait_drive(1, 1'b1);
        chk(control_word, word(ALT), "alternate word");
        return_req <= 1'b1;
        restore_order <= 1'b1;
        next_addr <= NXT;
        wait_drive(1, 1'b1);
        chk(microaddress_reg, A2, "return address");
        return_req <= 1'b0;
        restore_order <= 1'b0;
        wait_drive(1, 1'b1);
        chk(control_word, word(A2), "resumed word");
        chk(microaddress_reg, {NXT[14:2], 2'b10}, "restored branch");
    endtask : test_break
    // Address and sense parity, check stop
    task automatic test_parity;
        int hi;
        hi = 0;
        bus(OFF_MCHECK, 1'b1, 32'h0000_00FF);
        third_check_bit <= 1'b0;
        next_addr <= A1;
        wait_drive(2, 1'b1);
        third_check_bit <= 1'b1;
        rd_chk(OFF_MCHECK, 32'h0000_0020, 32'h0000_0020, "address check");
        bus(OFF_MCHECK, 1'b1, 32'h0000_00FF);
        next_addr <= BAD;
        bus(OFF_CONTROL, 1'b1, 32'h0000_0003);
        wait_drive(1, 1'b1);
        corrupt <= 1'b1;
        next_addr <= A1;
        wait_drive(1, 1'b0);
        repeat (300) begin
            @(posedge hclk);
            hi += int'(array_drive === 1'b1);
        end
        corrupt <= 1'b0;
        chk(32'(hi), 32'h0, "drive not blocked");
        chk(microaddress_reg, BAD, "failing address kept");
        rd_chk(OFF_MCHECK, 32'h0000_0018, 32'h0000_0018, "sense and control check");
        rd_chk(OFF_STATUS, 32'h0000_0040, 32'h0000_0040, "check stop");
    endtask : test_parity
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial begin
        #100000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        {hresetn, hsel, hwrite, break_req, return_req, restore_order, corrupt, cond_bit_b} = 8'h00;
        {cond_bit_a, third_check_bit} = 2'b11;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
        next_addr = A1;
        alt_start_addr = ALT;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        test_regs();
        test_stop();
        test_break();
        test_parity();
        end_of_test();
    end
endmodule : ustore_seq_tb
bind ustore_seq ustore_seq_monitor ustore_seq_monitor_i (.hclk, .hresetn, .cs_word, .break_req, .return_req,
    .microaddress_reg, .array_drive, .control_word);
